/* File: design/eeprom_pkg.sv */
// Constants, types and opcodes shared by the serial EEPROM command logic.
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package eeprom_pkg;

  localparam int ADDR_W_MAX = 9;
  localparam int PAGE_W     = 4;
  localparam int FIFO_DEPTH = 32;

  localparam logic [7:0] OP_SET_LATCH  = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH  = 8'h04;
  localparam logic [7:0] OP_STAT_READ  = 8'h05;
  localparam logic [7:0] OP_STAT_WRITE = 8'h01;
  localparam logic [2:0] OP_MEM_READ   = 3'h3;
  localparam logic [2:0] OP_MEM_WRITE  = 3'h2;
  localparam int         OP_ADDR9_BIT  = 3;

  localparam logic [3:0] STAT_ONES   = 4'hf;
  localparam int         STAT_BP_LO  = 2;
  localparam int         STAT_BP_HI  = 3;

  localparam logic [1:0] PROT_NONE    = 2'h0;
  localparam logic [1:0] PROT_QUARTER = 2'h1;
  localparam logic [1:0] PROT_HALF    = 2'h2;
  localparam logic [1:0] PROT_ALL     = 2'h3;
  localparam logic [1:0] BP_RESET     = 2'h0;

  localparam int CLK_MHZ          = 50;
  localparam int PROG_TIME_US     = 5000;
  localparam int PROG_CYCLES_DFLT = PROG_TIME_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_OPCODE = 3'b001,
    ST_ADDR   = 3'b010,
    ST_READ   = 3'b011,
    ST_STAT   = 3'b100,
    ST_WDATA  = 3'b101,
    ST_SRDATA = 3'b110,
    ST_IGNORE = 3'b111
  } phase_t;

  typedef struct packed {
    logic [ADDR_W_MAX-1:0] addr;
    logic [7:0]            data;
  } fifo_entry_t;

endpackage

/* File: design/spi_eeprom_core.sv */
// Serial EEPROM command, protection and program logic with its load FIFO.
`timescale 1ns/100ps
`default_nettype none

//----------------------------------------------------------------------
// Load FIFO
//----------------------------------------------------------------------
module load_fifo #(
  parameter int W     = 17,
  parameter int DEPTH = 32
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         clear,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW:0] wr;
    logic [PW:0] rd;
  } fifo_state_t;

  fifo_state_t        s_reg;
  fifo_state_t        s_next;
  logic [W-1:0]       mem [DEPTH];
  logic               push;
  logic               pop;

  assign in_ready  = (s_reg.wr[PW] == s_reg.rd[PW]) ||
                     (s_reg.wr[PW-1:0] != s_reg.rd[PW-1:0]);
  assign out_valid = s_reg.wr != s_reg.rd;
  assign out_data  = mem[s_reg.rd[PW-1:0]];
  assign push      = in_valid & in_ready & ~clear;
  assign pop       = out_valid & out_ready & ~clear;

  always_comb begin
    s_next = s_reg;
    if (clear) begin
      s_next.rd = s_reg.wr;
    end else begin
      if (push) begin
        s_next.wr = s_reg.wr + 1'b1;
      end
      if (pop) begin
        s_next.rd = s_reg.rd + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
    if (push) begin
      mem[s_reg.wr[PW-1:0]] <= in_data;
    end
  end
endmodule

//----------------------------------------------------------------------
// Command engine
//----------------------------------------------------------------------
module spi_eeprom_core #(
  parameter int ADDR_W      = 9,
  parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES_DFLT
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic chip_sel_n,
  input  wire logic ser_clk,
  input  wire logic ser_in,
  input  wire logic pause_n,
  input  wire logic write_guard_n,
  output logic      ser_out,
  output logic      ser_out_oe
);
  localparam int AM = eeprom_pkg::ADDR_W_MAX;
  localparam int TW = $clog2(PROG_CYCLES + 1);
  localparam logic [AM-1:0] ADDR_MASK = AM'((1 << ADDR_W) - 1);
  localparam logic [TW-1:0] T_LAST    = TW'(PROG_CYCLES - 1);

  typedef struct packed {
    logic [2:0]         cs_s;
    logic [2:0]         sck_s;
    logic [1:0]         si_s;
    logic [1:0]         hold_s;
    logic [1:0]         wg_s;
    eeprom_pkg::phase_t st;
    logic [7:0]         sh;
    logic [2:0]         bitcnt;
    logic [2:0]         obit;
    logic               addr_hi;
    logic               opw;
    logic [AM-1:0]      addr;
    logic               so;
    logic               so_oe;
    logic               latch;
    logic [1:0]         bp;
    logic [1:0]         pend_bp;
    logic               pend_set;
    logic               pend_sr;
    logic               sr_go;
    logic               got_byte;
    logic               spoiled;
    // Set by the first output bit of a frame, cleared when a frame opens.
    logic               talked;
    logic               busy;
    logic [TW-1:0]      timer;
  } core_state_t;

  core_state_t             s_reg;
  core_state_t             s_next;
  logic [7:0]              array_mem [1 << ADDR_W];
  logic [7:0]              mem_q;
  logic [7:0]              status;
  logic [7:0]              sh_in;
  logic [7:0]              src;
  logic                    sck_rise;
  logic                    sck_fall;
  logic                    cs_fall;
  logic                    cs_rise;
  logic                    active;
  logic                    byte_done;
  logic                    commit_ok;
  logic                    push;
  logic                    fifo_clear;
  logic                    in_ready;
  logic                    out_valid;
  eeprom_pkg::fifo_entry_t push_entry;
  eeprom_pkg::fifo_entry_t out_entry;

  function automatic logic protected_addr(input logic [AM-1:0] a,
                                          input logic [1:0]    bp);
    logic [ADDR_W-1:0] aa;
    aa = a[ADDR_W-1:0];
    case (bp)
      eeprom_pkg::PROT_NONE:    protected_addr = 1'b0;
      eeprom_pkg::PROT_QUARTER: protected_addr = &aa[ADDR_W-1:ADDR_W-2];
      eeprom_pkg::PROT_HALF:    protected_addr = aa[ADDR_W-1];
      default:                  protected_addr = 1'b1;
    endcase
  endfunction

  assign status = {eeprom_pkg::STAT_ONES, s_reg.bp, s_reg.latch, s_reg.busy};

  assign sck_rise  = s_reg.sck_s[1] & ~s_reg.sck_s[2];
  assign sck_fall  = ~s_reg.sck_s[1] & s_reg.sck_s[2];
  assign cs_fall   = ~s_reg.cs_s[1] & s_reg.cs_s[2];
  assign cs_rise   = s_reg.cs_s[1] & ~s_reg.cs_s[2];
  // pause gating
  // Pause and select each pass two flip-flops before use, so they stay aligned.
  assign active    = ~s_reg.cs_s[1] & s_reg.hold_s[1];
  assign sh_in     = {s_reg.sh[6:0], s_reg.si_s[1]};
  assign byte_done = s_reg.bitcnt == 3'd7;
  assign src       = (s_reg.st == eeprom_pkg::ST_READ) ? mem_q : status;
  assign commit_ok = s_reg.latch & s_reg.wg_s[1] & ~s_reg.spoiled &
                     ~s_reg.busy & (s_reg.bitcnt == 3'd0);
  assign ser_out    = s_reg.so;
  assign ser_out_oe = s_reg.so_oe;

  always_comb begin
    s_next        = s_reg;
    push          = 1'b0;
    fifo_clear    = 1'b0;
    push_entry    = '{addr: s_reg.addr, data: sh_in};
    s_next.cs_s   = {s_reg.cs_s[1:0], chip_sel_n};
    s_next.sck_s  = {s_reg.sck_s[1:0], ser_clk};
    s_next.si_s   = {s_reg.si_s[0], ser_in};
    s_next.hold_s = {s_reg.hold_s[0], pause_n};
    s_next.wg_s   = {s_reg.wg_s[0], write_guard_n};

    if (cs_fall) begin
      s_next.st        = eeprom_pkg::ST_OPCODE;
      s_next.bitcnt    = 3'd0;
      s_next.obit      = 3'd0;
      s_next.pend_set  = 1'b0;
      s_next.pend_sr   = 1'b0;
      s_next.talked    = 1'b0;
      s_next.got_byte  = 1'b0;
      s_next.spoiled   = 1'b0;
    end else if (active && sck_rise && s_reg.st != eeprom_pkg::ST_IDLE) begin
      s_next.sh     = sh_in;
      s_next.bitcnt = s_reg.bitcnt + 3'd1;
      case (s_reg.st)
        eeprom_pkg::ST_OPCODE: begin
          if (byte_done) begin
            s_next.st = eeprom_pkg::ST_IGNORE;
            if (s_reg.busy) begin
              if (sh_in == eeprom_pkg::OP_STAT_READ) begin
                s_next.st = eeprom_pkg::ST_STAT;
              end
            end else if (sh_in == eeprom_pkg::OP_SET_LATCH) begin
              s_next.pend_set = 1'b1;
            end else if (sh_in == eeprom_pkg::OP_CLR_LATCH) begin
              s_next.latch = 1'b0;
            end else if (sh_in == eeprom_pkg::OP_STAT_READ) begin
              s_next.st = eeprom_pkg::ST_STAT;
            end else if (sh_in == eeprom_pkg::OP_STAT_WRITE) begin
              s_next.st = eeprom_pkg::ST_SRDATA;
            end else if (sh_in[7:4] == 4'h0 &&
                         (sh_in[2:0] == eeprom_pkg::OP_MEM_READ ||
                          sh_in[2:0] == eeprom_pkg::OP_MEM_WRITE)) begin
              s_next.st  = eeprom_pkg::ST_ADDR;
              s_next.addr_hi = sh_in[eeprom_pkg::OP_ADDR9_BIT];
              s_next.opw = ~sh_in[0];
            end
          end
        end
        eeprom_pkg::ST_ADDR: begin
          if (byte_done) begin
            s_next.addr = {s_reg.addr_hi, sh_in} & ADDR_MASK;
            s_next.st   = s_reg.opw ? eeprom_pkg::ST_WDATA
                                    : eeprom_pkg::ST_READ;
          end
        end
        eeprom_pkg::ST_WDATA: begin
          if (byte_done) begin
            push            = 1'b1;
            s_next.got_byte = 1'b1;
            // Bytes beyond the FIFO's room spoil the whole write.
            if (!in_ready) begin
              s_next.spoiled = 1'b1;
            end
            s_next.addr[eeprom_pkg::PAGE_W-1:0] =
              s_reg.addr[eeprom_pkg::PAGE_W-1:0] + 4'd1;
          end
        end
        eeprom_pkg::ST_SRDATA: begin
          if (byte_done && !s_reg.pend_sr) begin
            s_next.pend_bp = {sh_in[eeprom_pkg::STAT_BP_HI],
                              sh_in[eeprom_pkg::STAT_BP_LO]};
            s_next.pend_sr = 1'b1;
          end
        end
        eeprom_pkg::ST_IGNORE: begin
          s_next.pend_set = 1'b0;
        end
        default: begin
        end
      endcase
    end

    if (!cs_fall && active && sck_fall &&
        (s_reg.st == eeprom_pkg::ST_READ ||
         s_reg.st == eeprom_pkg::ST_STAT)) begin
      s_next.so     = src[3'd7 - s_reg.obit];
      s_next.obit   = s_reg.obit + 3'd1;
      s_next.talked = 1'b1;
      if (s_reg.obit == 3'd7 && s_reg.st == eeprom_pkg::ST_READ) begin
        s_next.addr = (s_reg.addr + 9'd1) & ADDR_MASK;
      end
    end

    // guard drop mid-frame
    // A guard that dips and recovers inside a frame still cancels it.
    if (!s_reg.cs_s[1] && !s_reg.wg_s[1]) begin
      s_next.spoiled = 1'b1;
    end

    if (cs_rise) begin
      s_next.st = eeprom_pkg::ST_IDLE;
      // latch set on select rise
      // Any clock after the opcode clears the pending set, even a whole stray byte.
      if (s_reg.st == eeprom_pkg::ST_IGNORE && s_reg.pend_set &&
          s_reg.bitcnt == 3'd0) begin
        s_next.latch = 1'b1;
      end
      if (s_reg.st == eeprom_pkg::ST_WDATA && s_reg.got_byte &&
          commit_ok) begin
        s_next.busy  = 1'b1;
        s_next.timer = '0;
      end else if (s_reg.st == eeprom_pkg::ST_SRDATA && s_reg.pend_sr &&
                   commit_ok) begin
        s_next.busy  = 1'b1;
        s_next.sr_go = 1'b1;
        s_next.timer = '0;
      end
    end

    // Discard loaded bytes unless a write frame is still loading them or
    // a program cycle is draining them. Clearing during the load itself
    // would gate every push, so the frame keeps its bytes until it ends.
    if (!s_next.busy && s_next.st != eeprom_pkg::ST_WDATA) begin
      fifo_clear = 1'b1;
    end

    if (s_reg.busy) begin
      s_next.timer = s_reg.timer + 1'b1;
      if (s_reg.timer == T_LAST) begin
        s_next.busy  = 1'b0;
        s_next.latch = 1'b0;
        s_next.sr_go = 1'b0;
        if (s_reg.sr_go) begin
          s_next.bp = s_reg.pend_bp;
        end
      end
    end

    // output float
    // The frame remembers that it has started to answer, so the output
    // comes back by itself when a pause ends and no clock edge is needed.
    s_next.so_oe = active && !cs_rise &&
                   (s_next.st == eeprom_pkg::ST_READ ||
                    s_next.st == eeprom_pkg::ST_STAT) &&
                   s_next.talked;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_reg        <= '0;
      s_reg.cs_s   <= 3'b111;
      s_reg.sck_s  <= 3'b000;
      s_reg.hold_s <= 2'b11;
      s_reg.wg_s   <= 2'b11;
      s_reg.bp     <= eeprom_pkg::BP_RESET;
      s_reg.st     <= eeprom_pkg::ST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // The array keeps its contents through reset, as a nonvolatile store would.
  always_ff @(posedge sys_clk) begin
    mem_q <= array_mem[s_reg.addr[ADDR_W-1:0]];
    // Entries drain one per clock, well inside the shortest program time.
    // skip protected cells
    if (out_valid && s_reg.busy &&
        !protected_addr(out_entry.addr, s_reg.bp)) begin
      array_mem[out_entry.addr[ADDR_W-1:0]] <= out_entry.data;
    end
  end

  load_fifo #(
    .W     ($bits(eeprom_pkg::fifo_entry_t)),
    .DEPTH (eeprom_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .clear     (fifo_clear),
    .in_valid  (push),
    .in_ready  (in_ready),
    .in_data   (push_entry),
    .out_valid (out_valid),
    .out_ready (s_reg.busy),
    .out_data  (out_entry)
  );
endmodule

`default_nettype wire

/* File: test/spi_host_model.sv */
// Behavioural host controller that frames and shifts serial transfers.
`timescale 1ns/100ps
`default_nettype none
//----------------------------------------
// Host model
//----------------------------------------
module spi_host_model (
  input  wire logic sys_clk,
  input  wire logic ser_out,
  input  wire logic ser_out_oe,
  output var logic  chip_sel_n,
  output var logic  ser_clk,
  output var logic  ser_in,
  output var logic  pause_n
);
  logic idle_hi;
  logic oe_hold;
  initial begin
    chip_sel_n = 1'b1;
    ser_clk = 1'b0;
    ser_in = 1'b0;
    pause_n = 1'b1;
    idle_hi = 1'b0;
    oe_hold = 1'b0;
  end
  task automatic sel(input logic on);
    @(posedge sys_clk);
    #1;
    ser_clk = idle_hi;
    #200;
    chip_sel_n = !on;
    // A released data line flips so a stale bit can never pass.
    if (!on) ser_in = !ser_in;
    #200;
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                      input int hold = -1);
    for (int i = 7; i >= 0; i--) begin
      ser_clk = 1'b0;
      if (i == hold) begin
        // Let the falling edge act before the pause starts.
        #80;
        pause_n = 1'b0;
        #200;
        oe_hold = ser_out_oe;
        repeat (2) begin
          ser_in = !ser_in;
          ser_clk = 1'b1;
          #80;
          ser_clk = 1'b0;
          #80;
        end
        pause_n = 1'b1;
        #200;
      end
      ser_in = tx[i];
      #80;
      rx[i] = ser_out_oe ? ser_out : 1'bx;
      ser_clk = 1'b1;
      #80;
    end
  endtask
endmodule
`default_nettype wire

/* File: test/spi_eeprom_core_sva.sv */
// Port checker for the serial EEPROM command logic.
`timescale 1ns/100ps
`default_nettype none
module spi_eeprom_core_sva #(
  parameter int ADDR_W      = 9,
  parameter int PROG_CYCLES = 250000
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic chip_sel_n,
  input wire logic ser_clk,
  input wire logic ser_in,
  input wire logic pause_n,
  input wire logic write_guard_n,
  input wire logic ser_out,
  input wire logic ser_out_oe
);
  logic [2:0] cs_s;
  logic [2:0] ck_s;
  logic [7:0] op;
  logic [5:0] nb;
  logic       op_drives;
  //----------------------------------------
  // Opcode tracker
  //----------------------------------------
  // Own synchroniser, so bit counts lag the pins like the design's do.
  always_ff @(posedge sys_clk) begin
    cs_s <= {cs_s[1:0], chip_sel_n};
    ck_s <= {ck_s[1:0], ser_clk};
    if (rst || cs_s[2]) begin
      nb <= 6'h00;
    end else if (ck_s[1] && !ck_s[2] && pause_n && nb != 6'h3f) begin
      nb <= nb + 6'h01;
      if (nb < 6'h08) begin
        op <= {op[6:0], ser_in};
      end
    end
  end
  assign op_drives = op == 8'h05 || (op[7:4] == 4'h0 && op[2:0] == 3'h3);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_desel_float: assert property (chip_sel_n [*5] |-> !ser_out_oe)
    else $error("output driven while deselected");
  a_reset_quiet: assert property ($fell(rst) |-> !ser_out_oe && !ser_out)
    else $error("output active after reset");
  a_pause_float: assert property (!pause_n [*5] |-> !ser_out_oe)
    else $error("output driven while paused");
  a_out_on_fall: assert property (
    $changed(ser_out) && ser_out_oe && $past(ser_out_oe)
    |-> $past(ser_clk, 5) && !$past(ser_clk, 2))
    else $error("output bit moved off a falling clock");
  a_oe_on_fall: assert property (
    $rose(ser_out_oe) && $past(pause_n, 8)
    |-> $past(ser_clk, 5) && !$past(ser_clk, 2) && !chip_sel_n)
    else $error("output enabled off a falling clock");
  a_opcode_quiet: assert property (
    !chip_sel_n && nb < 6'h08 |-> !ser_out_oe)
    else $error("output driven during instruction byte");
  a_bad_code_quiet: assert property (
    !chip_sel_n && nb >= 6'h08 && !op_drives |-> !ser_out_oe)
    else $error("output driven for a non-read code");
  a_status_drives: assert property (
    !chip_sel_n && pause_n && nb == 6'h09 && op == 8'h05 |-> ser_out_oe)
    else $error("status read not answered");
endmodule
bind spi_eeprom_core spi_eeprom_core_sva #(
  .ADDR_W(ADDR_W), .PROG_CYCLES(PROG_CYCLES)
) u_spi_eeprom_core_sva (
  .sys_clk(sys_clk), .rst(rst), .chip_sel_n(chip_sel_n),
  .ser_clk(ser_clk), .ser_in(ser_in), .pause_n(pause_n),
  .write_guard_n(write_guard_n), .ser_out(ser_out),
  .ser_out_oe(ser_out_oe)
);
`default_nettype wire

/* File: test/spi_eeprom_core_tb.sv */
// Self-checking bench for the serial EEPROM command logic.
`timescale 1ns/100ps
`default_nettype none
module spi_eeprom_core_tb;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       write_guard_n = 1'b1;
  wire        chip_sel_n, ser_clk, ser_in, pause_n, ser_out, ser_out_oe;
  logic [7:0] rx;
  logic [8:0] lb;
  logic [7:0] shadow [0:511];
  int         failures = 0;
  int         n_checks = 0;
  always #10 sys_clk = !sys_clk;
  // Short program time keeps busy polling to a few frames.
  spi_eeprom_core #(.PROG_CYCLES(600)) u_spi_eeprom_core (
    .sys_clk(sys_clk), .rst(rst), .chip_sel_n(chip_sel_n),
    .ser_clk(ser_clk), .ser_in(ser_in), .pause_n(pause_n),
    .write_guard_n(write_guard_n), .ser_out(ser_out),
    .ser_out_oe(ser_out_oe));
  spi_host_model u_spi_host_model (
    .sys_clk(sys_clk), .ser_out(ser_out), .ser_out_oe(ser_out_oe),
    .chip_sel_n(chip_sel_n), .ser_clk(ser_clk), .ser_in(ser_in),
    .pause_n(pause_n));
  //----------------------------------------
  // Tasks
  //----------------------------------------
  task automatic finish_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    u_spi_host_model.sel(1'b1);
    u_spi_host_model.xfer(op, rx);
    u_spi_host_model.sel(1'b0);
  endtask
  task automatic frame2(input logic [7:0] op, input logic [7:0] b);
    u_spi_host_model.sel(1'b1);
    u_spi_host_model.xfer(op, rx);
    u_spi_host_model.xfer(b, rx);
    u_spi_host_model.sel(1'b0);
  endtask
  task automatic wait_ready();
    for (int k = 0; k < 20; k++) begin
      frame2(8'h05, 8'h00);
      check({rx[7:4], 4'h0}, 8'hf0);
      if (rx[0] === 1'b0) return;
    end
    failures++;
    finish_test();
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d,
                    input int n, input logic ok);
    cmd(8'h06);
    u_spi_host_model.sel(1'b1);
    u_spi_host_model.xfer({4'h0, a[8], 3'h2}, rx);
    u_spi_host_model.xfer(a[7:0], rx);
    for (int i = 0; i < n; i++) begin
      u_spi_host_model.xfer(d + 8'(i), rx);
      if (ok) shadow[{a[8:4], a[3:0] + 4'(i)}] = d + 8'(i);
    end
    u_spi_host_model.sel(1'b0);
  endtask
  task automatic rd(input logic [8:0] a, input int n, input int hold);
    u_spi_host_model.sel(1'b1);
    u_spi_host_model.xfer({4'h0, a[8], 3'h3}, rx);
    u_spi_host_model.xfer(a[7:0], rx);
    for (int i = 0; i < n; i++) begin
      u_spi_host_model.xfer(8'h00, rx, hold);
      check(rx, shadow[a + 9'(i)]);
    end
    u_spi_host_model.sel(1'b0);
  endtask
  //----------------------------------------
  // Sequence
  //----------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge sys_clk);
    for (int m = 0; m < 2; m++) begin
      u_spi_host_model.idle_hi = m[0];
      frame2(8'h05, 8'h00);
      check(rx, 8'hf0);
      cmd(8'h06);
      frame2(8'h05, 8'h00);
      check(rx, 8'hf2);
      cmd(8'h04);
      frame2(8'h05, 8'h00);
      check(rx, 8'hf0);
    end
    frame2(8'h06, 8'h00);
    frame2(8'h05, 8'h00);
    check(rx, 8'hf0);
    frame2(8'h85, 8'h00);
    check(rx, 8'hxx);
    wr(9'h010, 8'ha5, 1, 1'b1);
    frame2(8'h05, 8'h00);
    check(rx, 8'hf3);
    cmd(8'h04);
    frame2(8'h05, 8'h00);
    check(rx, 8'hf3);
    wait_ready();
    frame2(8'h05, 8'h00);
    check(rx, 8'hf0);
    frame2({4'h0, 1'b0, 3'h2}, 8'h10);
    wait_ready();
    @(posedge sys_clk);
    #1;
    write_guard_n = 1'b0;
    wr(9'h010, 8'h3c, 1, 1'b0);
    wait_ready();
    @(posedge sys_clk);
    #1;
    write_guard_n = 1'b1;
    rd(9'h010, 1, -1);
    fork
      wr(9'h010, 8'h5a, 1, 1'b0);
      begin
        repeat (150) @(posedge sys_clk);
        #1;
        write_guard_n = 1'b0;
        repeat (10) @(posedge sys_clk);
        #1;
        write_guard_n = 1'b1;
      end
    join
    wait_ready();
    rd(9'h010, 1, -1);
    wr(9'h11e, 8'h30, 4, 1'b1);
    wait_ready();
    rd(9'h11e, 2, -1);
    rd(9'h110, 2, 3);
    check({7'h00, u_spi_host_model.oe_hold}, 8'h00);
    // The rest runs with the clock idling low.
    u_spi_host_model.idle_hi = 1'b0;
    foreach (shadow[a]) begin
      if (a == 9'h1ff || a == 9'h000 || a == 9'h17f || a == 9'h180 ||
          a == 9'h0ff || a == 9'h100) begin
        wr(9'(a), 8'(a) ^ 8'h88, 1, 1'b1);
        wait_ready();
      end
    end
    rd(9'h1ff, 2, -1);
    for (int b = 1; b < 4; b++) begin
      lb = (b == 3) ? 9'h000 : 9'h000 - (9'h080 << (b - 1));
      cmd(8'h06);
      frame2(8'h01, {4'hf, 2'(b), 2'h3});
      wait_ready();
      frame2(8'h05, 8'h00);
      check(rx, {4'hf, 2'(b), 2'h0});
      wr(lb, 8'h40 + 8'(b), 1, 1'b0);
      wait_ready();
      wr(lb - 9'h001, 8'h50 + 8'(b), 1, b < 3);
      wait_ready();
      rd(lb - 9'h001, 2, -1);
    end
    finish_test();
  end
endmodule
`default_nettype wire
